// ===== hw/wiper_pkg.sv
package wiper_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int WIPER_W  = 6;
    localparam int NV_W     = 8;
    localparam int NUM_CH   = 4;
    localparam int NV_DEPTH = 16;
    localparam int FRAME_W  = 16;

    // ------------------------------------------------------------------
    // Nonvolatile store map
    // ------------------------------------------------------------------
    localparam logic [3:0] CHANNEL1_WIPER_NV  = 4'h0;
    localparam logic [3:0] CHANNEL2_WIPER_NV  = 4'h1;
    localparam logic [3:0] CHANNEL3_WIPER_NV  = 4'h2;
    localparam logic [3:0] CHANNEL4_WIPER_NV  = 4'h3;
    localparam logic [3:0] LOGIC_OUTPUTS_NV   = 4'h4;
    localparam logic [3:0] USER_BYTE_FIRST    = 4'h5;
    localparam logic [3:0] USER_BYTE_SECOND   = 4'h6;
    localparam logic [3:0] USER_BYTE_TENTH    = 4'hE;
    localparam logic [3:0] USER_BYTE_ELEVENTH = 4'hF;

    // Field positions inside the logic-output byte
    localparam int LOGIC_FIRST_BIT  = 0;
    localparam int LOGIC_SECOND_BIT = 1;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] NV_WIPER_RESET = 8'h20;
    localparam logic [7:0] NV_OTHER_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Wiper codes and counts
    // ------------------------------------------------------------------
    localparam logic [5:0] WIPER_ZERO = 6'h00;
    localparam logic [5:0] WIPER_ONE  = 6'h01;
    localparam logic [5:0] WIPER_MID  = 6'h20;
    localparam logic [5:0] WIPER_FULL = 6'h3F;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_NOP          = 4'h0;
    localparam logic [3:0] CMD_RESTORE_ONE  = 4'h1;
    localparam logic [3:0] CMD_STORE_WIPER  = 4'h2;
    localparam logic [3:0] CMD_STORE_BYTE   = 4'h3;
    localparam logic [3:0] CMD_RESTORE_ALL  = 4'h8;
    localparam logic [3:0] CMD_READ_NV      = 4'h9;
    localparam logic [3:0] CMD_READ_WIPER   = 4'hA;
    localparam logic [3:0] CMD_WRITE_WIPER  = 4'hB;

    // Step group decode bits: 4..7 and 12..15
    localparam int STEP_GROUP_BIT = 2;
    localparam int STEP_UP_BIT    = 3;
    localparam int STEP_LINEAR_BIT = 1;
    localparam int STEP_ALL_BIT   = 0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
        logic restore_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0, restore_n: 1'b1};

endpackage : wiper_pkg

// ===== hw/tap_decoder.sv
module tap_decoder #(
    parameter int CODE_W = 6
) (
    // Clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     rst_n_in,
    // Code in, one-hot taps out
    input  wire logic [CODE_W-1:0]        code_in,
    output logic      [(1<<CODE_W)-1:0]   tap_switch_out
);

    localparam int TAPS = 1 << CODE_W;

    // ------------------------------------------------------------------
    // One-hot tap select, tap 0 after reset
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tap_switch_out <= {{(TAPS-1){1'b0}}, 1'b1};
        end else begin
            tap_switch_out <= {{(TAPS-1){1'b0}}, 1'b1} << code_in;
        end
    end

endmodule : tap_decoder

// ===== hw/wiper_command_executor.sv

module wiper_command_executor #(
    parameter int NUM_CH = wiper_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                              core_clk_in,
    input  wire logic                              rst_n_in,
    // Serial link
    input  wire logic                              sclk_in,
    input  wire logic                              cs_n_in,
    input  wire logic                              sdi_in,
    output logic                                   sdo_out,
    output logic                                   sdo_oe_n_out,
    // Restore pin
    input  wire logic                              restore_pin_n_in,
    // Wiper state
    output logic [NUM_CH-1:0][wiper_pkg::WIPER_W-1:0]      wiper_register_out,
    output logic [NUM_CH-1:0][(1<<wiper_pkg::WIPER_W)-1:0] tap_switch_out,
    // Logic outputs and status
    output logic                                   logic_output_first_out,
    output logic                                   logic_output_second_out,
    output logic                                   read_power_state_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Synchronised pins and their edges
    wiper_pkg::pins_t                              pins_meta;
    wiper_pkg::pins_t                              pins_sync;
    wiper_pkg::pins_t                              pins_prev;
    logic                                          sclk_rise;
    logic                                          sclk_fall;
    logic                                          cs_fall;
    logic                                          cs_rise;
    logic                                          restore_fall;

    // Serial shifters
    logic [wiper_pkg::FRAME_W-1:0]                 shift_in;
    logic [wiper_pkg::FRAME_W-1:0]                 shift_out;
    logic [wiper_pkg::FRAME_W-1:0]                 echo_word;
    logic [wiper_pkg::FRAME_W-1:0]                 next_echo_word;
    logic [4:0]                                    bit_count;

    // Command decode
    wiper_pkg::frame_t                             frame;
    logic                                          exec;
    logic [1:0]                                    sel;
    logic                                          step_cmd;
    logic                                          restore_cmd;

    // Stored and volatile state
    logic                                          por_pending;
    logic [NUM_CH-1:0][wiper_pkg::WIPER_W-1:0]     wiper;
    logic [wiper_pkg::NV_W-1:0]                    nv_store [wiper_pkg::NV_DEPTH];
    logic [1:0]                                    logic_bits;

    // ------------------------------------------------------------------
    // Step function for increment, decrement and shifts
    // ------------------------------------------------------------------
    function automatic logic [wiper_pkg::WIPER_W-1:0] step_code(
        input logic [3:0]                    cmd,
        input logic [wiper_pkg::WIPER_W-1:0] code
    );
        logic [wiper_pkg::WIPER_W-1:0] result;

        result = code;
        // Linear step, held at both ends
        if (cmd[wiper_pkg::STEP_LINEAR_BIT]) begin
            if (cmd[wiper_pkg::STEP_UP_BIT]) begin
                if (code != wiper_pkg::WIPER_FULL) begin
                    result = code + 6'h01;
                end
            end else begin
                if (code != wiper_pkg::WIPER_ZERO) begin
                    result = code - 6'h01;
                end
            end
        end else begin
            // Left shift: zero loads one, midscale and up load full
            if (cmd[wiper_pkg::STEP_UP_BIT]) begin
                if (code == wiper_pkg::WIPER_ZERO) begin
                    result = wiper_pkg::WIPER_ONE;
                end else if (code >= wiper_pkg::WIPER_MID) begin
                    result = wiper_pkg::WIPER_FULL;
                end else begin
                    result = {code[wiper_pkg::WIPER_W-2:0], 1'b0};
                end
            end else begin
                // Right shift drops the LSB and sticks at zero
                result = {1'b0, code[wiper_pkg::WIPER_W-1:1]};
            end
        end
        return result;
    endfunction : step_code

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    // Idle levels at reset, so release brings no false edge
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pins_meta <= wiper_pkg::PINS_IDLE;
            pins_sync <= wiper_pkg::PINS_IDLE;
            pins_prev <= wiper_pkg::PINS_IDLE;
        end else begin
            pins_meta <= '{sclk:      sclk_in,
                           cs_n:      cs_n_in,
                           sdi:       sdi_in,
                           restore_n: restore_pin_n_in};
            pins_sync <= pins_meta;
            pins_prev <= pins_sync;
        end
    end

    assign sclk_rise    = pins_sync.sclk & ~pins_prev.sclk;
    assign sclk_fall    = ~pins_sync.sclk & pins_prev.sclk;
    assign cs_fall      = ~pins_sync.cs_n & pins_prev.cs_n;
    assign cs_rise      = pins_sync.cs_n & ~pins_prev.cs_n;
    assign restore_fall = ~pins_sync.restore_n & pins_prev.restore_n;

    // ------------------------------------------------------------------
    // Serial input register
    // ------------------------------------------------------------------
    // Only the last sixteen bits are kept, so longer daisy-chain frames
    // still execute on the trailing word.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_in  <= '0;
            bit_count <= '0;
        end else if (cs_fall) begin
            bit_count <= '0;
        end else if (sclk_rise && !pins_sync.cs_n) begin
            shift_in <= {shift_in[wiper_pkg::FRAME_W-2:0], pins_sync.sdi};
            // Saturate, so long frames still count as complete
            if (bit_count != wiper_pkg::FRAME_BITS) begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    assign frame    = wiper_pkg::frame_t'(shift_in);
    // Short frames end without executing
    assign exec     = cs_rise && (bit_count == wiper_pkg::FRAME_BITS);
    assign sel      = frame.addr[1:0];
    assign step_cmd = frame.cmd[wiper_pkg::STEP_GROUP_BIT];

    // ------------------------------------------------------------------
    // Serial output: echo or readback
    // ------------------------------------------------------------------
    always_comb begin
        next_echo_word = shift_in;
        // Readback replaces the echo only after read commands
        if (exec) begin
            case (frame.cmd)
                wiper_pkg::CMD_READ_NV: begin
                    next_echo_word = {frame.cmd, frame.addr, nv_store[frame.addr]};
                end
                wiper_pkg::CMD_READ_WIPER: begin
                    next_echo_word = {frame.cmd, frame.addr, 2'b00, wiper[sel]};
                end
                default: begin
                    next_echo_word = shift_in;
                end
            endcase
        end
    end

    // Frame end latches the word that the next frame shifts out
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            echo_word <= '0;
        end else if (cs_rise) begin
            echo_word <= next_echo_word;
        end
    end

    // Shift on the falling edge, so the host samples on rising
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_out <= '0;
        end else if (cs_fall) begin
            shift_out <= echo_word;
        end else if (sclk_fall && !pins_sync.cs_n) begin
            shift_out <= {shift_out[wiper_pkg::FRAME_W-2:0], 1'b0};
        end
    end

    assign sdo_out      = shift_out[wiper_pkg::FRAME_W-1];
    assign sdo_oe_n_out = pins_sync.cs_n;

    // ------------------------------------------------------------------
    // Power-on restore request
    // ------------------------------------------------------------------
    // High for only the first cycle after reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            por_pending <= 1'b1;
        end else begin
            por_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile store
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int a = 0; a < wiper_pkg::NV_DEPTH; a++) begin
                nv_store[a] <= (a < NUM_CH) ? wiper_pkg::NV_WIPER_RESET
                                            : wiper_pkg::NV_OTHER_RESET;
            end
        end else if (exec) begin
            case (frame.cmd)
                // Stored wiper keeps the upper two bits at zero
                wiper_pkg::CMD_STORE_WIPER: begin
                    nv_store[{2'b00, sel}] <= {2'b00, wiper[sel]};
                end
                // All eight bits land; wipers use the low six
                wiper_pkg::CMD_STORE_BYTE: begin
                    nv_store[frame.addr] <= frame.data;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wiper registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wiper <= {NUM_CH{wiper_pkg::NV_WIPER_RESET[wiper_pkg::WIPER_W-1:0]}};
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // Restores win over a command in the same cycle
                if (por_pending || restore_fall) begin
                    wiper[i] <= nv_store[i][wiper_pkg::WIPER_W-1:0];
                end else if (exec) begin
                    if (step_cmd) begin
                        // Broadcast variants skip the address compare
                        if (frame.cmd[wiper_pkg::STEP_ALL_BIT] || (sel == 2'(i))) begin
                            wiper[i] <= step_code(frame.cmd, wiper[i]);
                        end
                    end else begin
                        case (frame.cmd)
                            wiper_pkg::CMD_RESTORE_ONE: begin
                                if (sel == 2'(i)) begin
                                    wiper[i] <= nv_store[i][wiper_pkg::WIPER_W-1:0];
                                end
                            end
                            wiper_pkg::CMD_RESTORE_ALL: begin
                                wiper[i] <= nv_store[i][wiper_pkg::WIPER_W-1:0];
                            end
                            // Only the low six data bits reach the wiper
                            wiper_pkg::CMD_WRITE_WIPER: begin
                                if (sel == 2'(i)) begin
                                    wiper[i] <= frame.data[wiper_pkg::WIPER_W-1:0];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        end
    end

    assign wiper_register_out = wiper;

    // ------------------------------------------------------------------
    // Restore decode
    // ------------------------------------------------------------------
    // Both restore commands also reload the logic outputs
    assign restore_cmd = exec && ((frame.cmd == wiper_pkg::CMD_RESTORE_ONE) ||
                                  (frame.cmd == wiper_pkg::CMD_RESTORE_ALL));

    // ------------------------------------------------------------------
    // Logic outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            logic_bits <= wiper_pkg::NV_OTHER_RESET[1:0];
        end else if (por_pending || restore_cmd) begin
            logic_bits <= {nv_store[wiper_pkg::LOGIC_OUTPUTS_NV][wiper_pkg::LOGIC_SECOND_BIT],
                           nv_store[wiper_pkg::LOGIC_OUTPUTS_NV][wiper_pkg::LOGIC_FIRST_BIT]};
        end
    end

    assign logic_output_first_out  = logic_bits[0];
    assign logic_output_second_out = logic_bits[1];

    // ------------------------------------------------------------------
    // Read power state: set by single restore, left by a no-op
    // ------------------------------------------------------------------
    // Stays set across other commands until a no-op
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_power_state_out <= 1'b0;
        end else if (exec && (frame.cmd == wiper_pkg::CMD_RESTORE_ONE)) begin
            read_power_state_out <= 1'b1;
        end else if (exec && (frame.cmd == wiper_pkg::CMD_NOP)) begin
            read_power_state_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Tap decoders
    // ------------------------------------------------------------------
    // Registered, so taps trail the wiper code by one cycle
    for (genvar g = 0; g < NUM_CH; g++) begin : g_tap
        tap_decoder #(
            .CODE_W         (wiper_pkg::WIPER_W)
        ) u_tap (
            .core_clk_in    (core_clk_in),
            .rst_n_in       (rst_n_in),
            .code_in        (wiper[g]),
            .tap_switch_out (tap_switch_out[g])
        );
    end

endmodule : wiper_command_executor

// ===== verif/wiper_command_executor_asserts.sv
module wiper_command_executor_asserts #(
    parameter int NUM_CH = wiper_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic                                              core_clk_in,
    input wire logic                                              rst_n_in,
    // Serial link and restore pin
    input wire logic                                              sclk_in,
    input wire logic                                              cs_n_in,
    input wire logic                                              sdo_out,
    input wire logic                                              sdo_oe_n_out,
    input wire logic                                              restore_pin_n_in,
    // Wiper state and outputs
    input wire logic [NUM_CH-1:0][wiper_pkg::WIPER_W-1:0]         wiper_register_out,
    input wire logic [NUM_CH-1:0][(1<<wiper_pkg::WIPER_W)-1:0]    tap_switch_out,
    input wire logic                                              logic_output_first_out,
    input wire logic                                              logic_output_second_out
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int                 TAPS    = 1 << wiper_pkg::WIPER_W;
    localparam logic [TAPS-1:0]    ONE_TAP = {{(TAPS-1){1'b0}}, 1'b1};
    logic       [1:0]              up_cnt;
    logic                          quiet;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Frame in progress and no pin restore
    assign quiet = !cs_n_in && restore_pin_n_in;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_tap
        tap_decode_a: assert property ((up_cnt == 2'h3) |-> tap_switch_out[c] == (ONE_TAP << $past(wiper_register_out[c]))) else $error("tap does not follow wiper code");
        tap_onehot_a: assert property ($onehot(tap_switch_out[c])) else $error("tap select not one-hot");
    end
    wiper_hold_a: assert property (quiet [*6] |-> $stable(wiper_register_out)) else $error("wiper changed inside a frame");
    logic_hold_a: assert property (quiet [*6] |-> $stable({logic_output_first_out, logic_output_second_out})) else $error("logic outputs changed inside a frame");
    oe_on_a: assert property ($fell(cs_n_in) |-> ##[1:4] !sdo_oe_n_out) else $error("serial output not enabled");
    oe_off_a: assert property ($rose(cs_n_in) |-> ##[1:4] sdo_oe_n_out) else $error("serial output not released");
    sdo_steady_a: assert property ((!cs_n_in && sclk_in && $past(sclk_in, 5)) |-> $stable(sdo_out)) else $error("serial output moved while clock high");
    pin_logic_a: assert property (($fell(restore_pin_n_in) && cs_n_in) |-> ##1 $stable({logic_output_first_out, logic_output_second_out}) [*8]) else $error("pin restore touched logic outputs");

    frame_c: cover property ($rose(cs_n_in));
    pin_c: cover property ($fell(restore_pin_n_in));
    full_c: cover property (wiper_register_out[0] == wiper_pkg::WIPER_FULL);
endmodule : wiper_command_executor_asserts

// ===== verif/spi_host_model.sv
module spi_host_model (
    // Serial link towards the device
    output logic            sclk_out,
    output logic            cs_n_out,
    output logic            sdi_out,
    input  wire logic       sdo_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end

    // One framed transfer, MSB first, clock idle low; sdo sampled on each rise
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #2.7;
        cs_n_out = 1'b0;
        #80;
        for (int i = 15; i > 15 - nbits; i--) begin
            sdi_out = tx[i];
            #80;
            sclk_out = 1'b1;
            rx = {rx[14:0], sdo_in};
            #80;
            sclk_out = 1'b0;
        end
        #80;
        cs_n_out = 1'b1;
        // Released data line shows the inverse of its last value
        sdi_out = ~sdi_out;
        #160;
    endtask : xfer
endmodule : spi_host_model

// ===== verif/wiper_command_executor_tb_top.sv
module wiper_command_executor_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  core_clk_in, rst_n_in, sclk, cs_n, sdi, sdo, sdo_oe_n, restore_pin_n;
    logic [3:0][5:0]       wipers;
    logic [3:0][63:0]      taps;
    logic                  lo_first, lo_second, rps, erps, skip;
    logic [7:0]            nv [16];
    logic [5:0]            ew [4];
    logic [1:0]            elog;
    logic [15:0]           erx, rx;
    int                    errors, checks;
    localparam logic [15:0] FR [36] = '{16'hB010, 16'hE0A5, 16'hB13E, 16'hE1FF, 16'hE100,
        16'hB201, 16'h62C3, 16'h6200, 16'hF7FF, 16'h7000, 16'hB300, 16'hC3AA, 16'hC300,
        16'hB200, 16'hC200, 16'hC200, 16'hC200, 16'h4000, 16'h5000, 16'h5000, 16'hD000,
        16'h3455, 16'h3A9C, 16'h9A00, 16'hA300, 16'h2000, 16'hB03F, 16'h1000, 16'h0000,
        16'h3103, 16'h8000, 16'h3FA5, 16'h9F00, 16'h0000, 16'hC200, 16'hC200};

    spi_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));

    wiper_command_executor dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
        .restore_pin_n_in(restore_pin_n), .wiper_register_out(wipers), .tap_switch_out(taps),
        .logic_output_first_out(lo_first), .logic_output_second_out(lo_second),
        .read_power_state_out(rps));

    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_tap(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_tap

    function automatic logic [5:0] step_ref(input logic [3:0] c, input logic [5:0] w);
        case (c[3:1])
            3'h2:    return w >> 1;
            3'h3:    return (w == 6'h00) ? 6'h00 : w - 6'h01;
            3'h6:    return (w == 6'h00) ? 6'h01 : ((w >= 6'h20) ? 6'h3F : w << 1);
            default: return (w == 6'h3F) ? 6'h3F : w + 6'h01;
        endcase
    endfunction : step_ref

    task automatic check_state();
        for (int k = 0; k < 4; k++) begin
            chk_word({10'h000, wipers[k]}, {10'h000, ew[k]});
            chk_tap(taps[k], 64'h1 << ew[k]);
        end
        chk_word({14'h0000, lo_second, lo_first}, {14'h0000, elog});
        chk_word({15'h0000, rps}, {15'h0000, erps});
        chk_word({15'h0000, sdo_oe_n}, 16'h0001);
    endtask : check_state

    task automatic send(input logic [15:0] f);
        logic [3:0] c;
        logic [3:0] a;
        c = f[15:12];
        a = f[11:8];
        @(posedge core_clk_in);
        #1;
        host_u.xfer(f, 16, rx);
        if (!skip) chk_word(rx, erx);
        skip = 1'b0;
        erx = f;
        case (c)
            4'h0: erps = 1'b0;
            4'h1: begin
                ew[a[1:0]] = nv[a[1:0]][5:0];
                elog = nv[4][1:0];
                erps = 1'b1;
            end
            4'h2: nv[a[1:0]] = {2'b00, ew[a[1:0]]};
            4'h3: nv[a] = f[7:0];
            4'h8: begin
                for (int k = 0; k < 4; k++) ew[k] = nv[k][5:0];
                elog = nv[4][1:0];
            end
            4'h9: erx = {c, a, nv[a]};
            4'hA: erx = {c, a, 2'b00, ew[a[1:0]]};
            4'hB: ew[a[1:0]] = f[5:0];
            default: for (int k = 0; k < 4; k++) if (c[0] || k == a[1:0]) ew[k] = step_ref(c, ew[k]);
        endcase
        repeat (12) @(posedge core_clk_in);
        #1;
        check_state();
    endtask : send

    // A short frame must not execute
    task automatic short_frame();
        @(posedge core_clk_in);
        #1;
        host_u.xfer(16'hF000, 8, rx);
        skip = 1'b1;
        repeat (12) @(posedge core_clk_in);
        #1;
        check_state();
    endtask : short_frame

    // Pin restore reloads wipers only
    task automatic pin_restore();
        @(posedge core_clk_in);
        #1;
        restore_pin_n = 1'b0;
        repeat (10) @(posedge core_clk_in);
        #1;
        restore_pin_n = 1'b1;
        for (int k = 0; k < 4; k++) ew[k] = nv[k][5:0];
        repeat (10) @(posedge core_clk_in);
        #1;
        check_state();
    endtask : pin_restore

    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        #300000;
        errors++;
        conclude();
    end

    initial begin
        errors = 0;
        checks = 0;
        rst_n_in = 1'b0;
        restore_pin_n = 1'b1;
        skip = 1'b1;
        erps = 1'b0;
        elog = 2'h0;
        erx = 16'h0000;
        for (int k = 0; k < 16; k++) nv[k] = (k < 4) ? 8'h20 : 8'h00;
        for (int k = 0; k < 4; k++) ew[k] = 6'h20;
        repeat (3) @(posedge core_clk_in);
        #1;
        rst_n_in = 1'b1;
        repeat (6) @(posedge core_clk_in);
        #1;
        check_state();
        for (int i = 0; i < 36; i++) begin
            send(FR[i]);
            if (i == 20) short_frame();
            if (i == 29) pin_restore();
        end
        conclude();
    end
endmodule : wiper_command_executor_tb_top

bind wiper_command_executor wiper_command_executor_asserts #(.NUM_CH(NUM_CH)) chk_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
    .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out), .restore_pin_n_in(restore_pin_n_in),
    .wiper_register_out(wiper_register_out), .tap_switch_out(tap_switch_out),
    .logic_output_first_out(logic_output_first_out),
    .logic_output_second_out(logic_output_second_out));
